/* hw/hs_map.svh */
// register offsets, reset values and field positions of the homing sequencer
`ifndef HS_MAP_SVH
`define HS_MAP_SVH
`define HS_OFF_CTRL 8'h00
`define HS_OFF_SPEED 8'h04
`define HS_OFF_SHIFT 8'h08
`define HS_OFF_HOME 8'h0C
`define HS_OFF_RANGE 8'h10
`define HS_OFF_STATUS 8'h14
`define HS_OFF_IRQ_STAT 8'h18
`define HS_OFF_IRQ_MASK 8'h1C
`define HS_CTRL_START_DIR 0
`define HS_CTRL_POST_DIR 1
`define HS_CTRL_OT_ACTION 2
`define HS_CTRL_REF_SEL 3
`define HS_CTRL_LS_EDGE 4
`define HS_CTRL_SHIFT_SEL 5
`define HS_CTRL_CREEP_REV 6
`define HS_CTRL_RST 32'h0000_0020
`define HS_SPEED_RST 32'h1388_C350
`define HS_SHIFT_RST 32'h0000_03E8
`define HS_HOME_RST 32'h0000_0000
`define HS_RANGE_RST 32'h0000_0000
`define HS_IRQ_DONE 0
`define HS_IRQ_CANCEL 1
`define HS_IRQ_REVERSE 2
`define HS_RESP_OKAY 2'h0
`define HS_RESP_SLVERR 2'h2
`endif

/* hw/hs_pkg.sv */
// types shared by the homing sequencer and its bench
`default_nettype none
package hs_pkg;
    typedef enum logic [2:0] {
        S_IDLE,
        S_FAST,
        S_CREEP,
        S_SEEK,
        S_SHIFT
    } hs_state_t;
    // sensor and command pins, raw at the port and in each synchroniser stage
    typedef struct packed {
        logic homing_command;
        logic forward_overtravel_limit;
        logic reverse_overtravel_limit;
        logic home_limit_switch;
        logic index_pulse;
    } hs_sense_t;
    // motion request to the profile generator
    typedef struct packed {
        logic run;
        logic dir;
        logic [15:0] speed;
    } hs_motion_t;
endpackage
`default_nettype wire

/* hw/hs_homing_sequencer.sv */
// homing sequencer with AXI4-Lite register slave
// Function
// - a rising homing command starts travel in the start direction at homing speed.
// - the homing reference turns travel to the post-detection direction at creep speed.
// - after the limit switch in post travel, the first index pulse starts the shift travel.
// - shift end takes the stop point as home, raises completion and ends homing.
// - with overtravel action stop, either overtravel limit cancels homing at once.
// - the start-direction overtravel before the reference reverses the search once.
// - overtravel action resets to reverse (zero).
// - homing reference select zero means the limit switch and is the reset value.
// - limit switch edge select zero means rising edge and is the reset value.
// - shift reference select one means the index pulse and is the reset value.
// - a zero detection range keeps completion on once homing has finished.
// - creep reverse setting resets to zero, reverse rotation disabled.
// - completion loads the home coordinate into the current position.
// - a nonzero range gives completion only while position is within range of home.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "hs_map.svh"
`default_nettype none
module hs_homing_sequencer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // pins from sensors and encoder
    input wire hs_pkg::hs_sense_t sense_pins,
    input wire logic [31:0] cur_position,
    // motion and results
    output hs_pkg::hs_motion_t motion,
    output logic pos_load,
    output logic [31:0] pos_load_value,
    output logic home_done,
    output logic irq
);
    import hs_pkg::*;

    function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] d;
        d = a - b;
        return d[31] ? (32'h0000_0000 - d) : d;
    endfunction

    // two-stage synchronisers; stage one feeds stage two only
    hs_sense_t s1_ff, s2_ff, sd_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            sd_ff <= '0;
        end else begin
            s1_ff <= sense_pins;
            s2_ff <= s1_ff;
            sd_ff <= s2_ff;
        end
    end

    // registers
    logic [31:0] ctrl_ff, speed_ff, shift_ff, home_ff, range_ff;
    logic [2:0] istat_ff, imask_ff;
    logic [31:0] nxt_ctrl, nxt_speed, nxt_shift, nxt_home, nxt_range;
    logic [2:0] nxt_istat, nxt_imask;
    logic bvalid_ff, rvalid_ff, nxt_bvalid, nxt_rvalid;
    logic [1:0] bresp_ff, rresp_ff, nxt_bresp, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wr_go, rd_go;
    logic [2:0] ev;

    // sequencer state
    hs_state_t st_ff, nxt_st;
    logic dir_ff, nxt_dir, rev_ff, nxt_rev, homed_ff, nxt_homed;
    logic [31:0] mark_ff, nxt_mark;
    hs_motion_t mot_ff, nxt_mot;
    logic load_ff, nxt_load, done_ff, nxt_done;
    logic [31:0] lval_ff, nxt_lval;

    // edge events and decoded settings
    logic cmd_rise, ls_edge, idx_rise, ot_any, ot_fwd_dir, ref_hit, reached;
    logic ls_seen, ot_cancel;
    always_comb begin
        cmd_rise = s2_ff.homing_command && !sd_ff.homing_command;
        ls_edge = ctrl_ff[`HS_CTRL_LS_EDGE] ?
            (!s2_ff.home_limit_switch && sd_ff.home_limit_switch) :
            (s2_ff.home_limit_switch && !sd_ff.home_limit_switch);
        idx_rise = s2_ff.index_pulse && !sd_ff.index_pulse;
        ot_any = s2_ff.forward_overtravel_limit || s2_ff.reverse_overtravel_limit;
        ot_fwd_dir = dir_ff ? s2_ff.reverse_overtravel_limit : s2_ff.forward_overtravel_limit;
        // other reference choices fall back to the index pulse
        ref_hit = ctrl_ff[`HS_CTRL_REF_SEL] ? idx_rise : ls_edge;
        reached = absdiff(cur_position, mark_ff) >= shift_ff;
        // the switch counts as seen while it is made, so a post direction that keeps
        // running over it needs no second edge
        ls_seen = ls_edge || s2_ff.home_limit_switch;
        // reverse setting: bounce once off the limit ahead, then ignore that limit
        // while backing away from it, since the sensor stays made for a while
        if (ctrl_ff[`HS_CTRL_OT_ACTION]) begin
            ot_cancel = ot_any;
        end else if (rev_ff) begin
            ot_cancel = ot_fwd_dir;
        end else if (st_ff == S_FAST) begin
            ot_cancel = ot_any && !ot_fwd_dir;
        end else begin
            ot_cancel = ot_any;
        end
    end

    // sequencer next state
    always_comb begin
        nxt_st = st_ff;
        nxt_dir = dir_ff;
        nxt_rev = rev_ff;
        nxt_homed = homed_ff;
        nxt_mark = mark_ff;
        nxt_load = 1'b0;
        nxt_lval = lval_ff;
        ev = 3'b000;
        case (st_ff)
            S_IDLE: begin
                if (cmd_rise) begin
                    nxt_st = S_FAST;
                    nxt_dir = ctrl_ff[`HS_CTRL_START_DIR];
                    nxt_rev = 1'b0;
                    nxt_homed = 1'b0;
                end
            end
            S_FAST: begin
                if (ref_hit) begin
                    nxt_st = S_CREEP;
                    nxt_dir = ctrl_ff[`HS_CTRL_POST_DIR];
                end else if (ot_fwd_dir && !ctrl_ff[`HS_CTRL_OT_ACTION] && !rev_ff) begin
                    nxt_dir = !dir_ff;
                    nxt_rev = 1'b1;
                    ev[`HS_IRQ_REVERSE] = 1'b1;
                end
            end
            S_CREEP: begin
                // the index is not looked at here
                if (ls_seen) begin
                    nxt_st = ctrl_ff[`HS_CTRL_SHIFT_SEL] ? S_SEEK : S_SHIFT;
                    nxt_mark = cur_position;
                end
            end
            S_SEEK: begin
                if (idx_rise) begin
                    nxt_st = S_SHIFT;
                    nxt_mark = cur_position;
                end
            end
            S_SHIFT: begin
                if (reached) begin
                    nxt_st = S_IDLE;
                    nxt_homed = 1'b1;
                    nxt_load = 1'b1;
                    nxt_lval = home_ff;
                    ev[`HS_IRQ_DONE] = 1'b1;
                end
            end
            default: begin
                nxt_st = S_IDLE;
            end
        endcase
        // overtravel cancel, except for a shift end finishing in the same cycle
        if (st_ff != S_IDLE && ot_cancel && !nxt_load) begin
            nxt_st = S_IDLE;
            ev[`HS_IRQ_CANCEL] = 1'b1;
            ev[`HS_IRQ_REVERSE] = 1'b0;
        end
        nxt_mot.run = (nxt_st != S_IDLE);
        nxt_mot.dir = nxt_dir;
        nxt_mot.speed = (nxt_st == S_IDLE) ? 16'h0000 :
            (nxt_st == S_FAST) ? speed_ff[15:0] : speed_ff[31:16];
        // completion follows homed alone at zero range, else also the range window around home
        if (range_ff == 32'h0000_0000) begin
            nxt_done = nxt_homed;
        end else begin
            nxt_done = nxt_homed && (absdiff(cur_position, home_ff) <= range_ff);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= S_IDLE;
            dir_ff <= 1'b0;
            rev_ff <= 1'b0;
            homed_ff <= 1'b0;
            mark_ff <= 32'h0000_0000;
            mot_ff <= '0;
            load_ff <= 1'b0;
            lval_ff <= 32'h0000_0000;
            done_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            dir_ff <= nxt_dir;
            rev_ff <= nxt_rev;
            homed_ff <= nxt_homed;
            mark_ff <= nxt_mark;
            mot_ff <= nxt_mot;
            load_ff <= nxt_load;
            lval_ff <= nxt_lval;
            done_ff <= nxt_done;
        end
    end

    // bus handshake: both write channels are taken together, one answer outstanding
    assign wr_go = s_awvalid && s_wvalid && !bvalid_ff;
    assign rd_go = s_arvalid && !rvalid_ff;
    assign s_awready = wr_go;
    assign s_wready = wr_go;
    assign s_arready = rd_go;

    // register writes and read mux
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_speed = speed_ff;
        nxt_shift = shift_ff;
        nxt_home = home_ff;
        nxt_range = range_ff;
        nxt_imask = imask_ff;
        nxt_istat = istat_ff;
        nxt_bvalid = bvalid_ff && !s_bready;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff && !s_rready;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (wr_go) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = `HS_RESP_OKAY;
            case (s_awaddr)
                `HS_OFF_CTRL: nxt_ctrl = wmask(ctrl_ff, s_wdata, s_wstrb) & 32'h0000_007F;
                `HS_OFF_SPEED: nxt_speed = wmask(speed_ff, s_wdata, s_wstrb);
                `HS_OFF_SHIFT: nxt_shift = wmask(shift_ff, s_wdata, s_wstrb);
                `HS_OFF_HOME: nxt_home = wmask(home_ff, s_wdata, s_wstrb);
                `HS_OFF_RANGE: nxt_range = wmask(range_ff, s_wdata, s_wstrb);
                `HS_OFF_STATUS: nxt_bresp = `HS_RESP_OKAY;
                `HS_OFF_IRQ_STAT: begin
                    if (s_wstrb[0]) begin
                        nxt_istat = istat_ff & ~s_wdata[2:0];
                    end
                end
                `HS_OFF_IRQ_MASK: begin
                    if (s_wstrb[0]) begin
                        nxt_imask = s_wdata[2:0];
                    end
                end
                default: nxt_bresp = `HS_RESP_SLVERR;
            endcase
        end
        // a new event beats a clear in the same cycle
        nxt_istat = nxt_istat | ev;
        if (rd_go) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = `HS_RESP_OKAY;
            case (s_araddr)
                `HS_OFF_CTRL: nxt_rdata = ctrl_ff;
                `HS_OFF_SPEED: nxt_rdata = speed_ff;
                `HS_OFF_SHIFT: nxt_rdata = shift_ff;
                `HS_OFF_HOME: nxt_rdata = home_ff;
                `HS_OFF_RANGE: nxt_rdata = range_ff;
                `HS_OFF_STATUS: nxt_rdata = {26'h000_0000, done_ff, homed_ff, 1'b0, st_ff};
                `HS_OFF_IRQ_STAT: nxt_rdata = {29'h0000_0000, istat_ff};
                `HS_OFF_IRQ_MASK: nxt_rdata = {29'h0000_0000, imask_ff};
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = `HS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `HS_CTRL_RST;
            speed_ff <= `HS_SPEED_RST;
            shift_ff <= `HS_SHIFT_RST;
            home_ff <= `HS_HOME_RST;
            range_ff <= `HS_RANGE_RST;
            istat_ff <= 3'h0;
            imask_ff <= 3'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rresp_ff <= 2'h0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            speed_ff <= nxt_speed;
            shift_ff <= nxt_shift;
            home_ff <= nxt_home;
            range_ff <= nxt_range;
            istat_ff <= nxt_istat;
            imask_ff <= nxt_imask;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs
    assign s_bvalid = bvalid_ff;
    assign s_bresp = bresp_ff;
    assign s_rvalid = rvalid_ff;
    assign s_rresp = rresp_ff;
    assign s_rdata = rdata_ff;
    assign motion = mot_ff;
    assign pos_load = load_ff;
    assign pos_load_value = lval_ff;
    assign home_done = done_ff;
    assign irq = |(istat_ff & imask_ff);

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_shift_end;
        st_ff == S_SHIFT && reached && !ot_any;
    endsequence
    sequence s_homed_out;
        st_ff == S_IDLE ##0 homed_ff ##0 load_ff ##0 lval_ff == $past(home_ff);
    endsequence
    chk_start_fast: assert property ((st_ff == S_IDLE && cmd_rise) |=>
        st_ff == S_FAST && mot_ff.speed == $past(speed_ff[15:0]))
        else $error("start did not enter fast travel");
    chk_ref_creep: assert property ((st_ff == S_FAST && ref_hit && !ot_any) |=>
        st_ff == S_CREEP && mot_ff.speed == $past(speed_ff[31:16]))
        else $error("reference did not switch to creep");
    chk_index_ignored: assert property ((st_ff == S_CREEP && !ls_seen) |=>
        st_ff != S_SHIFT && st_ff != S_SEEK)
        else $error("index used before limit switch");
    chk_shift_home: assert property (s_shift_end |=> s_homed_out)
        else $error("shift end did not set home");
    chk_ot_cancel: assert property ((st_ff != S_IDLE && ot_any &&
        ctrl_ff[`HS_CTRL_OT_ACTION] && !(st_ff == S_SHIFT && reached)) |=>
        st_ff == S_IDLE && !mot_ff.run)
        else $error("overtravel did not cancel");
    chk_ot_reverse: assert property ((st_ff == S_FAST && !ref_hit && ot_fwd_dir &&
        !ctrl_ff[`HS_CTRL_OT_ACTION] && !rev_ff && !s2_ff.forward_overtravel_limit == dir_ff)
        |=> dir_ff != $past(dir_ff))
        else $error("overtravel did not reverse");
    chk_done_hold: assert property ((homed_ff && range_ff == 32'h0000_0000 &&
        st_ff == S_IDLE && !cmd_rise && $stable(range_ff)) |=>
        home_done ##1 (home_done || !homed_ff || $past(range_ff) != 32'h0000_0000))
        else $error("completion dropped with zero range");
    chk_done_window: assert property ((nxt_homed && range_ff != 32'h0000_0000 &&
        absdiff(cur_position, home_ff) > range_ff) |=> !home_done)
        else $error("completion outside range");
    chk_event_wins: assert property (ev[`HS_IRQ_DONE] |=> istat_ff[`HS_IRQ_DONE])
        else $error("done event lost");
endmodule
`default_nettype wire

/* tb/hs_axis_model.sv */
// axis model: integrates motion requests and decodes sensors from the position
`timescale 1ns/1ps
`default_nettype none
module hs_axis_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench controls
    input wire logic cmd,
    input wire logic [31:0] ls_lo,
    input wire logic [31:0] ot_hi,
    input wire logic [31:0] ot_lo,
    // sequencer side
    input wire hs_pkg::hs_motion_t motion,
    input wire logic pos_load,
    input wire logic [31:0] pos_load_value,
    output var hs_pkg::hs_sense_t sense_pins,
    output logic [31:0] cur_position
);
    import hs_pkg::*;
    logic signed [31:0] pos_ff;
    // one unit per cycle while running; speed only matters to the real drive
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pos_ff <= '0;
        else if (pos_load)
            pos_ff <= pos_load_value;
        else if (motion.run)
            pos_ff <= motion.dir ? pos_ff - 1 : pos_ff + 1;
    end
    // switch is 40 units wide; index every 64 units, so it may sit high at rest
    always_comb begin
        sense_pins.homing_command = cmd;
        sense_pins.home_limit_switch = pos_ff >= $signed(ls_lo)
            && pos_ff < $signed(ls_lo) + 32'sh0000_0028;
        sense_pins.index_pulse = pos_ff[5:0] == 6'h00;
        sense_pins.forward_overtravel_limit = pos_ff >= $signed(ot_hi);
        sense_pins.reverse_overtravel_limit = pos_ff <= $signed(ot_lo);
    end
    assign cur_position = pos_ff;
endmodule
`default_nettype wire

/* tb/homing_sequencer_bench.sv */
// self-checking bench for the homing sequencer
`timescale 1ns/1ps
`include "hs_map.svh"
`default_nettype none
module homing_sequencer_bench;
    import hs_pkg::*;
    logic aclk = 0, aresetn = 0, cmd = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, pos, plv, rd, p;
    logic [31:0] ls_lo = 32'h0000_0400, ot_hi = 32'h0000_001E, ot_lo = 32'hFFFF_FC00;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, pl, done, irq;
    logic [1:0] bresp, rresp, rs;
    hs_sense_t sp;
    hs_motion_t mo;
    int fails = 0, comparisons = 0;
    always #2.5 aclk = ~aclk;
    hs_homing_sequencer uut (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .sense_pins(sp),
        .cur_position(pos), .motion(mo), .pos_load(pl), .pos_load_value(plv),
        .home_done(done), .irq(irq));
    hs_axis_model axis (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .ls_lo(ls_lo),
        .ot_hi(ot_hi), .ot_lo(ot_lo), .motion(mo), .pos_load(pl),
        .pos_load_value(plv), .sense_pins(sp), .cur_position(pos));
    // compare and count
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one write; each channel released at its own handshake, bready held to the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(negedge aclk);
            ta = awready;
            tw = wready;
            tb = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            n++;
        end while (!tb && n < 50);
        bready <= 0;
        if (n >= 50) fails++;
    endtask
    // one read; data and response taken at the handshake edge
    task automatic rdw(input logic [7:0] a);
        logic ta, tv;
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(negedge aclk);
            ta = arready;
            tv = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 0;
            n++;
        end while (!tv && n < 50);
        rready <= 0;
        if (n >= 50) fails++;
    endtask
    // command pin held long enough to pass the synchroniser
    task automatic start();
        @(posedge aclk) cmd <= 1;
        repeat (8) @(posedge aclk);
        cmd <= 0;
        @(negedge aclk);
    endtask
    // waits for the home load pulse, keeping the position seen before the load
    task automatic wait_load();
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            p = pos;
            n++;
        end while (!pl && n < 3000);
        chk("load pulse", pl, 1);
        repeat (2) @(negedge aclk);
    endtask
    task automatic t_regs();
        rdw(`HS_OFF_CTRL);
        chk("ctrl reset", rd, 32'h0000_0020);
        rdw(`HS_OFF_SPEED);
        chk("speed reset", rd, 32'h1388_C350);
        rdw(`HS_OFF_SHIFT);
        chk("shift reset", rd, 32'h0000_03E8);
        rdw(`HS_OFF_RANGE);
        chk("range reset", rd, 32'h0000_0000);
        rdw(`HS_OFF_HOME);
        chk("home reset", rd, 32'h0000_0000);
        rdw(8'h40);
        chk("unmapped read", {rd[29:0], rs}, 32'h0000_0002);
        wr(8'h40, 32'h0000_0001);
        chk("unmapped write", rs, 2'h2);
        $display("test regs done");
    endtask
    task automatic t_ot_stop();
        wr(`HS_OFF_CTRL, 32'h0000_0024);
        start();
        chk("fast run", {mo.run, mo.dir}, 2'h2);
        chk("fast speed", mo.speed, 16'hC350);
        repeat (60) @(negedge aclk);
        chk("stop run", mo.run, 0);
        chk("masked irq", irq, 0);
        rdw(`HS_OFF_IRQ_STAT);
        chk("cancel status", rd, 32'h0000_0002);
        wr(`HS_OFF_IRQ_MASK, 32'h0000_0007);
        @(negedge aclk);
        chk("unmasked irq", irq, 1);
        wr(`HS_OFF_IRQ_STAT, 32'h0000_0007);
        @(negedge aclk);
        chk("cleared irq", irq, 0);
        $display("test overtravel stop done");
    endtask
    task automatic t_ot_rev();
        ls_lo <= 32'hFFFF_FF38;
        ot_hi <= 32'h0000_0050;
        wr(`HS_OFF_SHIFT, 32'h0000_0064);
        wr(`HS_OFF_CTRL, 32'h0000_0022);
        start();
        repeat (80) @(negedge aclk);
        chk("reversed motion", {mo.run, mo.dir}, 2'h3);
        rdw(`HS_OFF_IRQ_STAT);
        chk("reverse status", rd, 32'h0000_0004);
        wait_load();
        chk("reverse stop", ($signed(p) <= -292 && $signed(p) >= -306), 1);
        chk("reverse done", done, 1);
        wr(`HS_OFF_IRQ_STAT, 32'h0000_0007);
        $display("test overtravel reverse done");
    endtask
    task automatic t_basic();
        int n;
        n = 0;
        ls_lo <= 32'h0000_00C8;
        ot_hi <= 32'h0000_1388;
        ot_lo <= 32'hFFFF_EC78;
        wr(`HS_OFF_HOME, 32'h0000_0055);
        wr(`HS_OFF_CTRL, 32'h0000_0020);
        start();
        chk("fast speed", mo.speed, 16'hC350);
        while (mo.speed !== 16'h1388 && n < 1000) begin
            @(negedge aclk);
            n++;
        end
        chk("creep motion", {mo.run, mo.dir, mo.speed}, 18'h2_1388);
        wait_load();
        // index at 192 falls before the switch; the next one at 256 marks the shift
        chk("stop point", (p >= 356 && p <= 372), 1);
        chk("home value", plv, 32'h0000_0055);
        chk("stopped", {mo.run, done, irq}, 3'h3);
        rdw(`HS_OFF_IRQ_STAT);
        chk("done status", rd, 32'h0000_0001);
        wr(`HS_OFF_IRQ_STAT, 32'h0000_0001);
        $display("test basic done");
    endtask
    task automatic t_range();
        wr(`HS_OFF_RANGE, 32'h0000_0005);
        repeat (3) @(negedge aclk);
        chk("inside range", done, 1);
        wr(`HS_OFF_HOME, 32'h0000_0100);
        repeat (3) @(negedge aclk);
        chk("outside range", done, 0);
        wr(`HS_OFF_RANGE, 32'h0000_0000);
        repeat (3) @(negedge aclk);
        chk("range zero", done, 1);
        $display("test range done");
    endtask
    // start backwards, reference on leaving the switch, shift from coming back onto it
    task automatic t_falling();
        ls_lo <= 32'hFFFF_FF9C;
        wr(`HS_OFF_CTRL, 32'h0000_0011);
        start();
        chk("reverse start", {mo.run, mo.dir}, 2'h3);
        wait_load();
        // falls at -101, creep back onto the switch at -100, shift 100 from there
        chk("falling stop", ($signed(p) >= -2 && $signed(p) <= 12), 1);
        chk("second home", plv, 32'h0000_0100);
        $display("test falling edge done");
    endtask
    // verdict and end of run
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        t_regs();
        t_ot_stop();
        t_ot_rev();
        t_basic();
        t_range();
        t_falling();
        print_verdict();
    end
    // watchdog, well past the roughly 1300 cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
